/* File: hdl/uif_irq_fifo_ctrl.sv */
// Purpose: Interrupt enable, divisor high byte, identification and FIFO control registers.
// Assumes: Divisor access comes from the line control register outside this block.
// Notes:   FIFO levels are counts supplied by the FIFOs; all outputs are registered.
`timescale 1ns/10ps
module uif_irq_fifo_ctrl
	import uif_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int LW    = $clog2(DEPTH + 1)
)
(
	// Clock and reset.
	input  wire logic          REF_CLK_I,
	input  wire logic          RST_I,
	// Register port.
	input  wire logic [31:0]   ADDR_I,
	input  wire logic [15:0]   WDATA_I,
	input  wire logic          WR_I,
	input  wire logic          RD_I,
	output logic      [15:0]   RDATA_O,
	// State from the rest of the UART.
	input  wire logic          DIV_ACCESS_I,
	input  wire logic [LW-1:0] RX_LEVEL_I,
	input  wire logic [LW-1:0] TX_LEVEL_I,
	input  wire logic          LINE_STATUS_I,
	input  wire logic          CHAR_TIMEOUT_I,
	input  wire logic          MODEM_STATUS_I,
	input  wire logic          BUSY_DETECT_I,
	// Controls to the rest of the UART.
	output logic      [7:0]    BAUD_DIVISOR_HIGH_O,
	output logic               FIFO_ON_O,
	output logic               DMA_SIGNAL_MODE_O,
	output logic               TX_FIFO_CLEAR_O,
	output logic               RX_FIFO_CLEAR_O,
	output logic               RX_TRIGGER_HIT_O,
	output logic               TX_THRESHOLD_HIT_O,
	output logic               IRQ_O
);

	// Trigger and threshold counts in characters.
	localparam logic [LW-1:0] CNT_ONE     = LW'(1);
	localparam logic [LW-1:0] CNT_TWO     = LW'(2);
	localparam logic [LW-1:0] CNT_QUARTER = LW'(DEPTH / 4);
	localparam logic [LW-1:0] CNT_HALF    = LW'(DEPTH / 2);
	localparam logic [LW-1:0] CNT_NEAR    = LW'(DEPTH - 2);
	localparam logic [LW-1:0] CNT_ZERO    = LW'(0);

	logic [7:0]    irq_enable_reg_q;
	logic [7:0]    irq_enable_reg_d;
	logic [7:0]    baud_divisor_high_q;
	logic [7:0]    baud_divisor_high_d;
	logic          fifo_on_q;
	logic          fifo_on_d;
	logic [1:0]    rx_trigger_level_q;
	logic [1:0]    rx_trigger_level_d;
	logic [1:0]    tx_empty_threshold_q;
	logic [1:0]    tx_empty_threshold_d;
	logic          dma_signal_mode_q;
	logic          dma_signal_mode_d;
	logic          tx_fifo_clear_q;
	logic          tx_fifo_clear_d;
	logic          rx_fifo_clear_q;
	logic          rx_fifo_clear_d;
	logic [3:0]    pending_irq_code_q;
	logic          irq_q;
	logic [15:0]   rdata_q;
	logic [15:0]   rdata_d;
	logic          rx_hit_q;
	logic          tx_hit_q;
	logic          ier_sel;
	logic          iir_sel;
	logic [LW-1:0] rx_trig_cnt;
	logic [LW-1:0] tx_thr_cnt;
	logic          rx_hit;
	logic          tx_hit;
	logic          tx_holding_empty_hit;
	logic [UIF_SRC_NUM-1:0] pend;
	logic [3:0]    prio_code;
	logic          prio_any;

	// address decode
	// One address, two meanings: at the IIR address the strobe decides which register is touched, at the IER address DIV_ACCESS_I does.
	assign ier_sel = (ADDR_I == UIF_IER_ADDR);
	assign iir_sel = (ADDR_I == UIF_IIR_ADDR);

	// Register writes; the clear bits last one cycle because their next value defaults to zero.
	always_comb
	begin
		irq_enable_reg_d     = irq_enable_reg_q;
		baud_divisor_high_d  = baud_divisor_high_q;
		fifo_on_d            = fifo_on_q;
		rx_trigger_level_d   = rx_trigger_level_q;
		tx_empty_threshold_d = tx_empty_threshold_q;
		dma_signal_mode_d    = dma_signal_mode_q;
		tx_fifo_clear_d      = 1'b0;
		rx_fifo_clear_d      = 1'b0;
		if (WR_I && ier_sel)
		begin
			if (DIV_ACCESS_I)
			begin
				baud_divisor_high_d = WDATA_I[7:0];
			end
			else
			begin
				irq_enable_reg_d = WDATA_I[7:0] & UIF_IER_WMASK;
			end
		end
		if (WR_I && iir_sel)
		begin
			fifo_on_d            = WDATA_I[UIF_FCR_ON];
			rx_trigger_level_d   = WDATA_I[UIF_FCR_RT_LO +: 2];
			tx_empty_threshold_d = WDATA_I[UIF_FCR_TET_LO +: 2];
			dma_signal_mode_d    = WDATA_I[UIF_FCR_DMA];
			tx_fifo_clear_d      = WDATA_I[UIF_FCR_TXCLR];
			rx_fifo_clear_d      = WDATA_I[UIF_FCR_RXCLR];
		end
	end

	// Control register storage.
	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			irq_enable_reg_q     <= UIF_IER_RST;
			baud_divisor_high_q  <= UIF_DLH_RST;
			fifo_on_q            <= 1'b0;
			rx_trigger_level_q   <= UIF_FIELD_RST;
			tx_empty_threshold_q <= UIF_FIELD_RST;
			dma_signal_mode_q    <= 1'b0;
			tx_fifo_clear_q      <= 1'b0;
			rx_fifo_clear_q      <= 1'b0;
		end
		else
		begin
			irq_enable_reg_q     <= irq_enable_reg_d;
			baud_divisor_high_q  <= baud_divisor_high_d;
			fifo_on_q            <= fifo_on_d;
			rx_trigger_level_q   <= rx_trigger_level_d;
			tx_empty_threshold_q <= tx_empty_threshold_d;
			dma_signal_mode_q    <= dma_signal_mode_d;
			tx_fifo_clear_q      <= tx_fifo_clear_d;
			rx_fifo_clear_q      <= rx_fifo_clear_d;
		end
	end

	// Level comparisons; with FIFOs off a single character counts as the trigger.
	always_comb
	begin
		unique case (rx_trigger_level_q)
			2'h0: rx_trig_cnt = CNT_ONE;
			2'h1: rx_trig_cnt = CNT_QUARTER;
			2'h2: rx_trig_cnt = CNT_HALF;
			2'h3: rx_trig_cnt = CNT_NEAR;
		endcase
		unique case (tx_empty_threshold_q)
			2'h0: tx_thr_cnt = CNT_ZERO;
			2'h1: tx_thr_cnt = CNT_TWO;
			2'h2: tx_thr_cnt = CNT_QUARTER;
			2'h3: tx_thr_cnt = CNT_HALF;
		endcase
		rx_hit = fifo_on_q ? (RX_LEVEL_I >= rx_trig_cnt) : (RX_LEVEL_I != CNT_ZERO);
		tx_hit = fifo_on_q ? (TX_LEVEL_I <= tx_thr_cnt) : (TX_LEVEL_I == CNT_ZERO);
		// programmable empty mode
		// The threshold only shapes the interrupt in programmable mode with FIFOs on.
		tx_holding_empty_hit = (fifo_on_q && irq_enable_reg_q[UIF_IER_PROGRAMMABLE_EMPTY_IRQ_MODE]) ? tx_hit
			: (TX_LEVEL_I == CNT_ZERO);
	end

	// Enable gating of each source; busy detect cannot be masked.
	always_comb
	begin
		pend = '0;
		pend[UIF_SRC_LINE]   = irq_enable_reg_q[UIF_IER_LINE] && LINE_STATUS_I;
		pend[UIF_SRC_RXDATA] = irq_enable_reg_q[UIF_IER_RXDATA] && rx_hit;
		pend[UIF_SRC_TOUT]   = irq_enable_reg_q[UIF_IER_RXDATA] && fifo_on_q
			&& CHAR_TIMEOUT_I;
		pend[UIF_SRC_TX_HOLDING_EMPTY]   = irq_enable_reg_q[UIF_IER_TX_HOLDING_EMPTY] && tx_holding_empty_hit;
		pend[UIF_SRC_MODEM]  = irq_enable_reg_q[UIF_IER_MODEM] && MODEM_STATUS_I;
		pend[UIF_SRC_BUSY]   = BUSY_DETECT_I;
	end

	uif_irq_prio u_prio
	(
		.pend_i (pend),
		.code_o (prio_code),
		.any_o  (prio_any)
	);

	// Read mux; data stand only in the cycle after the read strobe.
	always_comb
	begin
		rdata_d = 16'h0000;
		if (RD_I && ier_sel)
		begin
			rdata_d[7:0] = DIV_ACCESS_I ? baud_divisor_high_q : irq_enable_reg_q;
		end
		else if (RD_I && iir_sel)
		begin
			rdata_d[7:6] = {2{fifo_on_q}};
			rdata_d[3:0] = pending_irq_code_q;
		end
	end

	// Status and output registers.
	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			pending_irq_code_q <= UIF_ID_NONE;
			irq_q              <= 1'b0;
			rdata_q            <= 16'h0000;
			rx_hit_q           <= 1'b0;
			tx_hit_q           <= 1'b0;
		end
		else
		begin
			pending_irq_code_q <= prio_code;
			irq_q              <= prio_any;
			rdata_q            <= rdata_d;
			rx_hit_q           <= rx_hit;
			tx_hit_q           <= tx_hit;
		end
	end

	assign RDATA_O             = rdata_q;
	assign BAUD_DIVISOR_HIGH_O = baud_divisor_high_q;
	assign FIFO_ON_O           = fifo_on_q;
	assign DMA_SIGNAL_MODE_O   = dma_signal_mode_q;
	assign TX_FIFO_CLEAR_O     = tx_fifo_clear_q;
	assign RX_FIFO_CLEAR_O     = rx_fifo_clear_q;
	assign RX_TRIGGER_HIT_O    = rx_hit_q;
	assign TX_THRESHOLD_HIT_O  = tx_hit_q;
	assign IRQ_O               = irq_q;

	// Checks of the register and interrupt behaviour.
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	sequence ier_wr_s;
		WR_I && ier_sel;
	endsequence

	sequence iir_wr_s;
		WR_I && iir_sel;
	endsequence

	div_write_a: assert property (ier_wr_s and DIV_ACCESS_I |=>
		BAUD_DIVISOR_HIGH_O == $past(WDATA_I[7:0]) && $stable(irq_enable_reg_q))
		else $error("divisor high byte not written");

	enable_write_a: assert property (ier_wr_s and !DIV_ACCESS_I |=>
		irq_enable_reg_q == ($past(WDATA_I[7:0]) & UIF_IER_WMASK))
		else $error("enable register write wrong");

	fifo_flags_read_a: assert property (RD_I && iir_sel |=>
		RDATA_O[7:6] == {2{$past(fifo_on_q)}} && RDATA_O[15:8] == 8'h00)
		else $error("FIFO state flags wrong");

	tx_clear_pulse_a: assert property (iir_wr_s and WDATA_I[UIF_FCR_TXCLR] |=>
		TX_FIFO_CLEAR_O ##1 (!TX_FIFO_CLEAR_O || $past(WR_I && iir_sel)))
		else $error("transmit clear not a single pulse");

	rx_clear_pulse_a: assert property (RX_FIFO_CLEAR_O |->
		$past(WR_I && iir_sel && WDATA_I[UIF_FCR_RXCLR]))
		else $error("receive clear without a write");

	irq_follow_a: assert property (##1 IRQ_O == $past(|pend))
		else $error("interrupt output does not follow pending sources");

	line_top_a: assert property (pend[UIF_SRC_LINE] |=>
		pending_irq_code_q == UIF_ID_LINE)
		else $error("line status not reported first");

	modem_gate_a: assert property (pending_irq_code_q == UIF_ID_MODEM |->
		$past(irq_enable_reg_q[UIF_IER_MODEM] && MODEM_STATUS_I))
		else $error("modem status reported while masked");

	rx_trigger_hit_a: assert property (fifo_on_q && RX_LEVEL_I >= rx_trig_cnt |=>
		RX_TRIGGER_HIT_O)
		else $error("receive trigger level missed");

	rdata_idle_a: assert property (!RD_I |=> RDATA_O == 16'h0000)
		else $error("read data shown without a read");

	fifo_on_write_a: assert property (iir_wr_s |=>
		FIFO_ON_O == $past(WDATA_I[UIF_FCR_ON]))
		else $error("FIFO enable not taken from write");

endmodule : uif_irq_fifo_ctrl

/* File: shared/uif_pkg.sv */
// Purpose: Shared constants for the UART interrupt enable, identification and FIFO control.
// Assumes: Registers sit on a plain 32-bit byte address port with 16-bit data.
// Notes:   Reserved bits are held at zero by write masks and read zero padding.
package uif_pkg;

	// Register byte addresses.
	localparam logic [31:0] UIF_IER_ADDR   = 32'h50001104;
	localparam logic [31:0] UIF_IIR_ADDR   = 32'h50001108;

	// Enable register fields and writable mask.
	localparam int          UIF_IER_RXDATA = 0;
	localparam int          UIF_IER_TX_HOLDING_EMPTY   = 1;
	localparam int          UIF_IER_LINE   = 2;
	localparam int          UIF_IER_MODEM  = 3;
	localparam int          UIF_IER_PROGRAMMABLE_EMPTY_IRQ_MODE  = 7;
	localparam logic [7:0]  UIF_IER_WMASK  = 8'h8F;

	// FIFO control fields.
	localparam int          UIF_FCR_ON     = 0;
	localparam int          UIF_FCR_RXCLR  = 1;
	localparam int          UIF_FCR_TXCLR  = 2;
	localparam int          UIF_FCR_DMA    = 3;
	localparam int          UIF_FCR_TET_LO = 4;
	localparam int          UIF_FCR_RT_LO  = 6;

	// Reset values.
	localparam logic [7:0]  UIF_IER_RST    = 8'h00;
	localparam logic [7:0]  UIF_DLH_RST    = 8'h00;
	localparam logic [1:0]  UIF_FIELD_RST  = 2'h0;

	// Pending interrupt codes.
	localparam logic [3:0]  UIF_ID_MODEM   = 4'h0;
	localparam logic [3:0]  UIF_ID_NONE    = 4'h1;
	localparam logic [3:0]  UIF_ID_TX_HOLDING_EMPTY    = 4'h2;
	localparam logic [3:0]  UIF_ID_RXDATA  = 4'h4;
	localparam logic [3:0]  UIF_ID_LINE    = 4'h6;
	localparam logic [3:0]  UIF_ID_BUSY    = 4'h7;
	localparam logic [3:0]  UIF_ID_TIMEOUT = 4'hC;

	// Source index order in the pending vector, highest priority first.
	localparam int          UIF_SRC_LINE   = 0;
	localparam int          UIF_SRC_RXDATA = 1;
	localparam int          UIF_SRC_TOUT   = 2;
	localparam int          UIF_SRC_TX_HOLDING_EMPTY   = 3;
	localparam int          UIF_SRC_MODEM  = 4;
	localparam int          UIF_SRC_BUSY   = 5;
	localparam int          UIF_SRC_NUM    = 6;

endpackage : uif_pkg

/* File: hdl/uif_irq_prio.sv */
// Purpose: Priority encoder that turns pending sources into one identification code.
// Assumes: Pending bits are already gated by their enables.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module uif_irq_prio
	import uif_pkg::*;
(
	// Pending sources, index 0 highest.
	input  wire logic [UIF_SRC_NUM-1:0] pend_i,
	// Encoded result.
	output logic      [3:0]             code_o,
	output logic                        any_o
);

	// Codes per source, in the same order as the pending vector.
	localparam logic [3:0] CODES [UIF_SRC_NUM] = '{UIF_ID_LINE, UIF_ID_RXDATA,
		UIF_ID_TIMEOUT, UIF_ID_TX_HOLDING_EMPTY, UIF_ID_MODEM, UIF_ID_BUSY};

	// single highest code
	// Walk from lowest to highest so the highest pending source is written last.
	always_comb
	begin
		code_o = UIF_ID_NONE;
		for (int i = UIF_SRC_NUM - 1; i >= 0; i--)
		begin
			if (pend_i[i])
			begin
				code_o = CODES[i];
			end
		end
		any_o = |pend_i;
	end

endmodule : uif_irq_prio

/* File: verification/uif_far_model.sv */
// Purpose: Behavioural model of the FIFO counters that sit around the control block.
// Assumes: The bench loads wanted counts; the clear pulses come from the block.
// Notes:   A clear wins over a load in the same cycle, as the real FIFO would.
`timescale 1ns/10ps
module uif_far_model
(
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Bench requests.
	input  wire logic       load_i,
	input  wire logic [4:0] rx_want_i,
	input  wire logic [4:0] tx_want_i,
	// Clear pulses from the block.
	input  wire logic       rx_clr_i,
	input  wire logic       tx_clr_i,
	// Counts seen by the block.
	output logic      [4:0] rx_level_o,
	output logic      [4:0] tx_level_o
);
	logic [4:0] rx_q;
	logic [4:0] rx_d;
	logic [4:0] tx_q;
	logic [4:0] tx_d;

	always_comb
	begin
		rx_d = load_i ? rx_want_i : rx_q;
		tx_d = load_i ? tx_want_i : tx_q;
		if (rx_clr_i)
			rx_d = 5'h00;
		if (tx_clr_i)
			tx_d = 5'h00;
	end

	// The counts are registered so the block sees them one edge after a load.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_q <= 5'h00;
			tx_q <= 5'h00;
		end
		else
		begin
			rx_q <= rx_d;
			tx_q <= tx_d;
		end
	end

	assign rx_level_o = rx_q;
	assign tx_level_o = tx_q;
endmodule : uif_far_model

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the interrupt enable, identification and FIFO control.
// Assumes: Register port answers a read in the following cycle only.
// Notes:   Source levels are driven here; FIFO counts come from the far model.
`timescale 1ns/10ps
module testbench
	import uif_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] addr = 32'h0;
	logic [15:0] wdata = 16'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        div = 1'b0;
	logic [3:0]  src = 4'h0;
	logic        load = 1'b0;
	logic [4:0]  rx_want = 5'h0;
	logic [4:0]  tx_want = 5'h0;
	logic [15:0] rdata;
	logic [15:0] d;
	logic [4:0]  rxl;
	logic [4:0]  txl;
	logic [7:0]  baud_divisor_high;
	logic        fon, dma, txc, rxc, rhit, thit, irq;
	int          fail_count = 0;
	int          checks = 0;
	int          rxt[4] = '{1, 4, 8, 14};
	int          txt[4] = '{0, 2, 4, 8};

	always #5 clk = ~clk;

	uif_irq_fifo_ctrl u_dut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DIV_ACCESS_I(div), .RX_LEVEL_I(rxl),
		.TX_LEVEL_I(txl), .LINE_STATUS_I(src[0]), .CHAR_TIMEOUT_I(src[1]),
		.MODEM_STATUS_I(src[2]), .BUSY_DETECT_I(src[3]), .BAUD_DIVISOR_HIGH_O(baud_divisor_high),
		.FIFO_ON_O(fon), .DMA_SIGNAL_MODE_O(dma), .TX_FIFO_CLEAR_O(txc),
		.RX_FIFO_CLEAR_O(rxc), .RX_TRIGGER_HIT_O(rhit), .TX_THRESHOLD_HIT_O(thit),
		.IRQ_O(irq));

	uif_far_model u_far (.clk_i(clk), .rst_i(rst), .load_i(load), .rx_want_i(rx_want),
		.tx_want_i(tx_want), .rx_clr_i(rxc), .tx_clr_i(txc), .rx_level_o(rxl),
		.tx_level_o(txl));

	// Comparison with four-state equality so an unknown never matches.
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	// One-cycle write strobe; the next task waits an edge before driving again.
	task automatic wr_reg(input logic [31:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data is sampled in the single cycle after the strobe edge.
	task automatic rd_reg(input logic [31:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg

	task automatic set_src(input logic [3:0] s, input logic [4:0] r, input logic [4:0] t);
		@(posedge clk);
		src <= s;
		rx_want <= r;
		tx_want <= t;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : set_src

	// Source order in s is busy, modem, timeout, line; FIFOs are on here.
	task automatic prio(input logic [3:0] s, input logic [4:0] r, input logic [4:0] t,
		input logic [3:0] code);
		set_src(s, r, t);
		rd_reg(UIF_IIR_ADDR, d);
		chk("pending code", {8'h00, 4'hC, code}, d);
		chk("irq", 16'(code != UIF_ID_NONE), 16'(irq));
	endtask : prio

	task automatic t_reset;
		rd_reg(UIF_IER_ADDR, d);
		chk("enable reset", 16'h0000, d);
		rd_reg(UIF_IIR_ADDR, d);
		chk("ident reset", 16'h0001, d);
		rd_reg(32'h50001100, d);
		chk("unmapped read", 16'h0000, d);
		chk("divisor reset", 16'h0000, 16'(baud_divisor_high));
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs;
		wr_reg(UIF_IER_ADDR, 16'hFFFF);
		rd_reg(UIF_IER_ADDR, d);
		chk("enable readback", 16'h008F, d);
		// The access select is moved on a clock edge like every other input.
		@(posedge clk);
		div <= 1'b1;
		wr_reg(UIF_IER_ADDR, 16'h005A);
		#1 chk("divisor out", 16'h005A, 16'(baud_divisor_high));
		rd_reg(UIF_IER_ADDR, d);
		chk("divisor read", 16'h005A, d);
		@(posedge clk);
		div <= 1'b0;
		rd_reg(UIF_IER_ADDR, d);
		chk("enable kept", 16'h008F, d);
		$display("test regs done");
	endtask : t_regs

	task automatic t_fifo;
		set_src(4'h0, 5'h05, 5'h05);
		wr_reg(UIF_IIR_ADDR, 16'h0007);
		#1 chk("clear pulses", 16'h0007, 16'({rxc, txc, fon}));
		@(posedge clk);
		#1 chk("clear self", 16'h0001, 16'({rxc, txc, fon}));
		rd_reg(UIF_IIR_ADDR, d);
		chk("fifo state on", 16'h0003, 16'(d[7:6]));
		wr_reg(UIF_IIR_ADDR, 16'h0008);
		#1 chk("dma mode", 16'h0002, 16'({dma, fon}));
		rd_reg(UIF_IIR_ADDR, d);
		chk("fifo state off", 16'h0000, 16'(d[7:6]));
		$display("test fifo done");
	endtask : t_fifo

	task automatic t_prio;
		wr_reg(UIF_IER_ADDR, 16'h000F);
		wr_reg(UIF_IIR_ADDR, 16'h0001);
		prio(4'hF, 5'h01, 5'h00, UIF_ID_LINE);
		prio(4'hE, 5'h01, 5'h00, UIF_ID_RXDATA);
		prio(4'hE, 5'h00, 5'h00, UIF_ID_TIMEOUT);
		prio(4'hC, 5'h00, 5'h00, UIF_ID_TX_HOLDING_EMPTY);
		prio(4'hC, 5'h00, 5'h03, UIF_ID_MODEM);
		prio(4'h8, 5'h00, 5'h03, UIF_ID_BUSY);
		prio(4'h0, 5'h00, 5'h03, UIF_ID_NONE);
		wr_reg(UIF_IER_ADDR, 16'h0000);
		prio(4'h7, 5'h01, 5'h00, UIF_ID_NONE);
		wr_reg(UIF_IER_ADDR, 16'h0082);
		wr_reg(UIF_IIR_ADDR, 16'h0011);
		prio(4'h0, 5'h00, 5'h02, UIF_ID_TX_HOLDING_EMPTY);
		wr_reg(UIF_IER_ADDR, 16'h0002);
		prio(4'h0, 5'h00, 5'h02, UIF_ID_NONE);
		$display("test priority done");
	endtask : t_prio

	// Every trigger and threshold code, one step short of and at its count.
	task automatic t_trig;
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(UIF_IIR_ADDR, {8'h00, i[1:0], i[1:0], 4'h1});
			set_src(4'h0, 5'(rxt[i] - 1), 5'(txt[i] + 1));
			chk("short of level", 16'h0000, 16'({rhit, thit}));
			set_src(4'h0, 5'(rxt[i]), 5'(txt[i]));
			chk("at level", 16'h0003, 16'({rhit, thit}));
		end
		$display("test trigger done");
	endtask : t_trig

	// A reset in mid-run must bring every register back, and read data last one cycle.
	task automatic t_rst;
		wr_reg(UIF_IER_ADDR, 16'h0001);
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1 chk("reset outputs", 16'h0000,
			16'({baud_divisor_high, fon, dma, txc, rxc, rhit, thit, irq}));
		rd_reg(UIF_IER_ADDR, d);
		chk("enable after reset", 16'h0000, d);
		rd_reg(UIF_IIR_ADDR, d);
		chk("ident after reset", 16'h0001, d);
		@(posedge clk);
		#1 chk("read data gone", 16'h0000, rdata);
		$display("test mid reset done");
	endtask : t_rst

	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_fifo();
		t_prio();
		t_trig();
		t_rst();
		test_done();
	end

	// Cuts a hang short and counts it as a mismatch.
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		test_done();
	end
endmodule : testbench
